/* File: design/flash_prot_pkg.sv */
// Operation
// - High disable bit enables top region when 0.
// - High size written only while high disable set.
// - Low disable bit enables bottom region when 0.
// - Low size written only while low disable set.
// - High size code selects top span.
// - Low size code selects span from 0x4000.
// - Polarity one protects each enabled range.
// - Polarity zero, both disabled: whole array protected.
// - Polarity zero: enabled ranges alone are unprotected.
// - Software may rewrite protection after reset load.
// - Writes may keep or add protection only.
// - Disallowed transition write is discarded entirely.
// - Reads return the protection currently in force.
// - Scenario 7 goes anywhere; 6 to 1,3,4,6.
// - Reset loads register from stored protection byte.
// - Polarity bit may only go from 1 to 0.
// - Protected program or erase refused, violation raised.
// - Mass erase only with polarity and disables set.
package flash_prot_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] CTL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // Field positions inside the protection register.
  localparam int POLARITY_BIT  = 7;
  localparam int SPARE_BIT     = 6;
  localparam int HI_DIS_BIT    = 5;
  localparam int HI_SIZE_MSB   = 4;
  localparam int HI_SIZE_LSB   = 3;
  localparam int LO_DIS_BIT    = 2;
  localparam int LO_SIZE_MSB   = 1;
  localparam int LO_SIZE_LSB   = 0;

  // Field positions inside the status register.
  localparam int VIOL_BIT      = 0;
  localparam int MASS_OK_BIT   = 1;

  // Address in the array that holds the protection byte loaded at reset.
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hFF0D;

  // Start addresses of the high range for each size code.
  localparam logic [15:0] HI_START_0 = 16'hF800;
  localparam logic [15:0] HI_START_1 = 16'hF000;
  localparam logic [15:0] HI_START_2 = 16'hE000;
  localparam logic [15:0] HI_START_3 = 16'hC000;

  // Low range always starts here; end address depends on size code.
  localparam logic [15:0] LO_START   = 16'h4000;
  localparam logic [15:0] LO_END_0   = 16'h41FF;
  localparam logic [15:0] LO_END_1   = 16'h43FF;
  localparam logic [15:0] LO_END_2   = 16'h47FF;
  localparam logic [15:0] LO_END_3   = 16'h4FFF;

  // Scenario index is polarity, high disable, low disable from the top bit down.
  function automatic logic [2:0] scenario_of(input logic [7:0] ctl);
    scenario_of = {ctl[POLARITY_BIT], ctl[HI_DIS_BIT], ctl[LO_DIS_BIT]};
  endfunction

  // Which region classes are protected, as {high, middle, low}.
  function automatic logic [2:0] classes_of(input logic [2:0] scn);
    if (scn[2]) begin
      classes_of = {~scn[1], 1'b0, ~scn[0]};
    end else begin
      classes_of = {scn[1], 1'b1, scn[0]};
    end
  endfunction

endpackage

/* File: design/flash_range_decode.sv */
`timescale 1ns/10ps
// Decides whether one flash address lies in a protected area.
module flash_range_decode (
  // Address under test.
  input  wire logic [15:0] addr_i,
  // Current protection setting.
  input  wire logic [7:0]  ctl_i,
  // Result.
  output logic             protected_o
);

  logic [15:0] hi_start;  // First address of the high range.
  logic [15:0] lo_end;    // Last address of the low range.
  logic        in_hi;     // Address falls in the high range.
  logic        in_lo;     // Address falls in the low range.
  logic        hi_on;     // High range is enabled.
  logic        lo_on;     // Low range is enabled.

  // Pick span bounds from the size codes and classify the address.
  always_comb begin
    case (ctl_i[flash_prot_pkg::HI_SIZE_MSB:flash_prot_pkg::HI_SIZE_LSB])
      2'h0:    hi_start = flash_prot_pkg::HI_START_0;
      2'h1:    hi_start = flash_prot_pkg::HI_START_1;
      2'h2:    hi_start = flash_prot_pkg::HI_START_2;
      default: hi_start = flash_prot_pkg::HI_START_3;
    endcase
    case (ctl_i[flash_prot_pkg::LO_SIZE_MSB:flash_prot_pkg::LO_SIZE_LSB])
      2'h0:    lo_end = flash_prot_pkg::LO_END_0;
      2'h1:    lo_end = flash_prot_pkg::LO_END_1;
      2'h2:    lo_end = flash_prot_pkg::LO_END_2;
      default: lo_end = flash_prot_pkg::LO_END_3;
    endcase
    in_hi = (addr_i >= hi_start);
    in_lo = (addr_i >= flash_prot_pkg::LO_START) && (addr_i <= lo_end);
    hi_on = ~ctl_i[flash_prot_pkg::HI_DIS_BIT];
    lo_on = ~ctl_i[flash_prot_pkg::LO_DIS_BIT];
    if (ctl_i[flash_prot_pkg::POLARITY_BIT]) begin
      // Enabled ranges are the protected ones.
      protected_o = (hi_on && in_hi) || (lo_on && in_lo);
    end else begin
      // Everything is protected except the enabled ranges.
      protected_o = !((hi_on && in_hi) || (lo_on && in_lo));
    end
  end

endmodule

/* File: design/flash_sector_protection.sv */
`timescale 1ns/10ps
// Flash protection register with an APB slave and a program/erase gate.
module flash_sector_protection (
  // Clock and synchronous active-low reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // APB slave port.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Protection byte read from the array during reset.
  input  wire logic [7:0]  nvm_prot_byte_i,
  // Program or erase request from the command controller.
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_mass_erase_i,
  input  wire logic [15:0] cmd_addr_i,
  // Verdicts toward the command controller.
  output logic             cmd_accepted_o,
  output logic             cmd_refused_o,
  output logic             protect_violation_flag_o,
  output logic             mass_erase_ok_o,
  output logic [7:0]       prot_ctl_o
);

  logic [7:0]  flash_protection_ctl_ff;   // Protection setting in force.
  logic [7:0]  nxt_flash_protection_ctl;  // Next protection setting.
  logic [7:0]  cand_ctl;                  // Write value after field filtering.
  logic        wr_allowed;                // Candidate keeps or adds protection.
  logic        viol_ff;                   // Sticky protect violation.
  logic        nxt_viol;                  // Next violation flag.
  logic        viol_set;                  // Request hits protection this cycle.
  logic        viol_clr;                  // Software write-one clear.
  logic        mass_ok_ff;                // Mass erase permitted.
  logic        nxt_mass_ok;               // Next mass erase permission.
  logic        acc_ff;                    // Accepted verdict pulse.
  logic        nxt_acc;                   // Next accepted pulse.
  logic        ref_ff;                    // Refused verdict pulse.
  logic        nxt_ref;                   // Next refused pulse.
  logic        pready_ff;                 // Access phase ready.
  logic        nxt_pready;                // Next ready.
  logic [31:0] prdata_ff;                 // Read data for the access phase.
  logic [31:0] nxt_prdata;                // Next read data.
  logic        pslverr_ff;                // Unmapped address error.
  logic        nxt_pslverr;               // Next error.
  logic        setup;                     // APB setup cycle.
  logic        commit_wr;                 // Write takes effect this edge.
  logic        addr_prot;                 // Request address is protected.
  logic        sel_ctl;                   // Address decodes to protection register.
  logic        sel_status;                // Address decodes to status register.

  // Combinational address check against the setting in force.
  flash_range_decode u_decode (
    .addr_i      (cmd_addr_i),
    .ctl_i       (flash_protection_ctl_ff),
    .protected_o (addr_prot)
  );

  // APB decode: one wait-free access phase after every setup cycle.
  always_comb begin
    setup       = psel_i && !penable_i;
    commit_wr   = psel_i && penable_i && pready_ff && pwrite_i;
    sel_ctl     = (paddr_i == flash_prot_pkg::CTL_OFFSET);
    sel_status  = (paddr_i == flash_prot_pkg::STATUS_OFFSET);
    nxt_pready  = setup;
    nxt_pslverr = setup && !sel_ctl && !sel_status;
    nxt_prdata  = 32'h0000_0000;
    if (setup && !pwrite_i) begin
      if (sel_ctl) begin
        // Always the setting in force, not the last value written.
        nxt_prdata = {24'h00_0000, flash_protection_ctl_ff};
      end else if (sel_status) begin
        nxt_prdata = {30'h0000_0000, mass_ok_ff, viol_ff};
      end
    end
  end

  // Filter a write field by field, then check the scenario transition.
  always_comb begin
    cand_ctl = flash_protection_ctl_ff;
    // Polarity may only be cleared; a one written over a zero stays zero.
    cand_ctl[flash_prot_pkg::POLARITY_BIT] =
      flash_protection_ctl_ff[flash_prot_pkg::POLARITY_BIT]
      & pwdata_i[flash_prot_pkg::POLARITY_BIT];
    // The spare flag only comes from the array byte.
    cand_ctl[flash_prot_pkg::HI_DIS_BIT] = pwdata_i[flash_prot_pkg::HI_DIS_BIT];
    cand_ctl[flash_prot_pkg::LO_DIS_BIT] = pwdata_i[flash_prot_pkg::LO_DIS_BIT];
    if (flash_protection_ctl_ff[flash_prot_pkg::HI_DIS_BIT]) begin
      cand_ctl[flash_prot_pkg::HI_SIZE_MSB:flash_prot_pkg::HI_SIZE_LSB] =
        pwdata_i[flash_prot_pkg::HI_SIZE_MSB:flash_prot_pkg::HI_SIZE_LSB];
    end
    if (flash_protection_ctl_ff[flash_prot_pkg::LO_DIS_BIT]) begin
      cand_ctl[flash_prot_pkg::LO_SIZE_MSB:flash_prot_pkg::LO_SIZE_LSB] =
        pwdata_i[flash_prot_pkg::LO_SIZE_MSB:flash_prot_pkg::LO_SIZE_LSB];
    end
    // A target must protect every class that the present scenario protects.
    wr_allowed =
      ((flash_prot_pkg::classes_of(flash_prot_pkg::scenario_of(flash_protection_ctl_ff))
        & ~flash_prot_pkg::classes_of(flash_prot_pkg::scenario_of(cand_ctl)))
       == 3'h0);
    nxt_flash_protection_ctl = flash_protection_ctl_ff;
    if (commit_wr && sel_ctl && wr_allowed) begin
      nxt_flash_protection_ctl = cand_ctl;
    end
    // Otherwise the whole write is dropped.
    nxt_mass_ok = nxt_flash_protection_ctl[flash_prot_pkg::POLARITY_BIT]
                  && nxt_flash_protection_ctl[flash_prot_pkg::HI_DIS_BIT]
                  && nxt_flash_protection_ctl[flash_prot_pkg::LO_DIS_BIT];
  end

  // Program/erase gate and sticky violation flag; a new hit beats a clear.
  always_comb begin
    viol_clr = commit_wr && sel_status && pwdata_i[flash_prot_pkg::VIOL_BIT];
    if (cmd_mass_erase_i) begin
      viol_set = cmd_valid_i && !mass_ok_ff;
    end else begin
      viol_set = cmd_valid_i && addr_prot;
    end
    nxt_viol = viol_set || (viol_ff && !viol_clr);
    nxt_ref  = viol_set;
    nxt_acc  = cmd_valid_i && !viol_set;
  end

  // Registers; reset loads the stored protection byte.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flash_protection_ctl_ff <= nvm_prot_byte_i;
      mass_ok_ff <= nvm_prot_byte_i[flash_prot_pkg::POLARITY_BIT]
                    & nvm_prot_byte_i[flash_prot_pkg::HI_DIS_BIT]
                    & nvm_prot_byte_i[flash_prot_pkg::LO_DIS_BIT];
      viol_ff    <= 1'b0;
      acc_ff     <= 1'b0;
      ref_ff     <= 1'b0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      flash_protection_ctl_ff <= nxt_flash_protection_ctl;
      mass_ok_ff <= nxt_mass_ok;
      viol_ff    <= nxt_viol;
      acc_ff     <= nxt_acc;
      ref_ff     <= nxt_ref;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata_o                 = prdata_ff;
  assign pready_o                 = pready_ff;
  assign pslverr_o                = pslverr_ff;
  assign cmd_accepted_o           = acc_ff;
  assign cmd_refused_o            = ref_ff;
  assign protect_violation_flag_o = viol_ff;
  assign mass_erase_ok_o          = mass_ok_ff;
  assign prot_ctl_o               = flash_protection_ctl_ff;

  // Checks on the logic above.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Helper: protected classes now, for the no-reduction check.
  logic [2:0] cls_now;
  assign cls_now =
    flash_prot_pkg::classes_of(flash_prot_pkg::scenario_of(flash_protection_ctl_ff));

  sequence s_ctl_write;
    commit_wr && sel_ctl;
  endsequence

  sequence s_prot_hit;
    cmd_valid_i && !cmd_mass_erase_i && addr_prot;
  endsequence

  property p_hi_size_hold;
    s_ctl_write and !flash_protection_ctl_ff[5] |=> $stable(flash_protection_ctl_ff[4:3]);
  endproperty
  a_hi_size_hold: assert property (p_hi_size_hold) else $error("high size changed");

  property p_lo_size_hold;
    s_ctl_write and !flash_protection_ctl_ff[2] |=> $stable(flash_protection_ctl_ff[1:0]);
  endproperty
  a_lo_size_hold: assert property (p_lo_size_hold) else $error("low size changed");

  property p_polarity_sticky;
    !flash_protection_ctl_ff[7] |=> !flash_protection_ctl_ff[7];
  endproperty
  a_polarity_sticky: assert property (p_polarity_sticky) else $error("polarity rose");

  property p_no_reduce;
    1'b1 |=> (($past(cls_now) & ~cls_now) == 3'h0);
  endproperty
  a_no_reduce: assert property (p_no_reduce) else $error("protection reduced");

  property p_discard_full;
    s_ctl_write and !wr_allowed |=> $stable(flash_protection_ctl_ff);
  endproperty
  a_discard_full: assert property (p_discard_full) else $error("bad write kept");

  property p_read_ctl;
    setup && !pwrite_i && sel_ctl
      |=> pready_o && prdata_o == {24'h00_0000, $past(flash_protection_ctl_ff)};
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("read data wrong");

  property p_mass_refuse;
    cmd_valid_i && cmd_mass_erase_i && !mass_erase_ok_o |=> cmd_refused_o && protect_violation_flag_o;
  endproperty
  a_mass_refuse: assert property (p_mass_refuse) else $error("mass erase let through");

  property p_prot_refuse;
    // The flag rises together with the refusal, not a cycle later.
    s_prot_hit |=> cmd_refused_o && !cmd_accepted_o && protect_violation_flag_o;
  endproperty
  a_prot_refuse: assert property (p_prot_refuse) else $error("protected access passed");

  property p_set_wins;
    s_prot_hit and viol_clr |=> protect_violation_flag_o;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("violation lost on clear");

  property p_full_array;
    // The spare bit is left out: it does not take part in the scenario.
    cmd_valid_i && !cmd_mass_erase_i && !flash_protection_ctl_ff[7]
      && flash_protection_ctl_ff[5] && flash_protection_ctl_ff[2]
      |=> cmd_refused_o;
  endproperty
  a_full_array: assert property (p_full_array) else $error("full protection leaked");

  property p_reset_load;
    @(posedge mclk_i) disable iff (1'b0)
      !rst_n_i |=> flash_protection_ctl_ff == $past(nvm_prot_byte_i);
  endproperty
  a_reset_load: assert property (p_reset_load) else $error("reset load wrong");

endmodule

/* File: test/test_flash_sector_protection.sv */
`timescale 1ns/10ps
// Compare macro: counts every check and reports each mismatch at once.
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
// Self-checking bench for the flash protection register and program/erase gate.
module test_flash_sector_protection;
  logic        mclk_i;           // Module clock, 40 MHz.
  logic        rst_n_i;          // Synchronous reset, active low.
  logic        psel_i;           // APB select.
  logic        penable_i;        // APB enable.
  logic        pwrite_i;         // APB direction.
  logic [7:0]  paddr_i;          // APB byte address.
  logic [31:0] pwdata_i;         // APB write data.
  logic [31:0] prdata_o;         // APB read data.
  logic        pready_o;         // APB ready.
  logic        pslverr_o;        // APB error.
  logic [7:0]  nvm_prot_byte_i;  // Stored protection byte.
  logic        cmd_valid_i;      // Program or erase request.
  logic        cmd_mass_erase_i; // Request is a mass erase.
  logic [15:0] cmd_addr_i;       // Target address.
  logic        cmd_accepted_o;   // Request accepted.
  logic        cmd_refused_o;    // Request refused.
  logic        protect_violation_flag_o; // Sticky violation.
  logic        mass_erase_ok_o;  // Mass erase permitted.
  logic [7:0]  prot_ctl_o;       // Setting in force.
  int          n_errors;         // Mismatches seen.
  int          n_checks;         // Comparisons made.
  logic [31:0] rd;               // Last read data.
  logic        er;               // Last error response.

  flash_sector_protection dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .nvm_prot_byte_i(nvm_prot_byte_i), .cmd_valid_i(cmd_valid_i),
    .cmd_mass_erase_i(cmd_mass_erase_i), .cmd_addr_i(cmd_addr_i),
    .cmd_accepted_o(cmd_accepted_o), .cmd_refused_o(cmd_refused_o),
    .protect_violation_flag_o(protect_violation_flag_o), .mass_erase_ok_o(mass_erase_ok_o),
    .prot_ctl_o(prot_ctl_o));

  // Clock generator, 25 ns period.
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Holds reset for 20 cycles while the array presents the given protection byte.
  task automatic do_reset(input logic [7:0] b);
    rst_n_i <= 1'b0;
    nvm_prot_byte_i <= b;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
  endtask

  // One APB transfer; the answer is taken at the rising edge that sees pready high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_errors++;
      $display("Error pready expected 1 seen %b", pready_o);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Writes the protection register, then reads it back and checks both views.
  task automatic wr_ctl(input logic [7:0] v, input logic [7:0] exp);
    apb(1'b1, flash_prot_pkg::CTL_OFFSET, {24'h000000, v});
    apb(1'b0, flash_prot_pkg::CTL_OFFSET, 32'h00000000);
    `CHK("ctl read", {24'h000000, exp}, rd)
    `CHK("ctl port", exp, prot_ctl_o)
  endtask

  // Issues one request and checks the verdict one cycle later.
  task automatic cmd(input logic m, input logic [15:0] a, input logic refuse);
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_mass_erase_i <= m;
    cmd_addr_i <= a;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    @(negedge mclk_i);
    `CHK("refused", refuse, cmd_refused_o)
    `CHK("accepted", ~refuse, cmd_accepted_o)
    if (refuse) `CHK("violation", 1'b1, protect_violation_flag_o)
  endtask

  // Reset load, size writes while disabled, spare bit kept.
  task automatic t_reset_sizes();
    // The array byte keeps the spare flag in its erased state.
    do_reset(8'hE4);
    @(negedge mclk_i);
    `CHK("reset load", 8'hE4, prot_ctl_o)
    `CHK("mass ok", 1'b1, mass_erase_ok_o)
    cmd(1'b1, 16'h0000, 1'b0);
    wr_ctl(8'hBE, 8'hFE);
    $display("Test reset_sizes done");
  endtask

  // Protect high range, boundary addresses, mass erase and flag clear, then add the low range.
  task automatic t_high();
    wr_ctl(8'h9E, 8'hDE);
    cmd(1'b0, 16'hC000, 1'b1);
    cmd(1'b0, 16'hBFFF, 1'b0);
    cmd(1'b0, 16'h4000, 1'b0);
    cmd(1'b1, 16'h0000, 1'b1);
    apb(1'b0, flash_prot_pkg::STATUS_OFFSET, 32'h00000000);
    `CHK("status", 32'h00000001, rd)
    apb(1'b1, flash_prot_pkg::STATUS_OFFSET, 32'h00000001);
    apb(1'b0, flash_prot_pkg::STATUS_OFFSET, 32'h00000000);
    `CHK("status clr", 32'h00000000, rd)
    wr_ctl(8'hBE, 8'hDE);
    wr_ctl(8'h86, 8'hDE);
    wr_ctl(8'h9B, 8'hDB);
    cmd(1'b0, 16'h4FFF, 1'b1);
    cmd(1'b0, 16'h5000, 1'b0);
    $display("Test high done");
  endtask

  // Polarity zero: full protection and the one-way polarity bit.
  task automatic t_polarity();
    do_reset(8'hE4);
    wr_ctl(8'h24, 8'h64);
    cmd(1'b0, 16'h8000, 1'b1);
    wr_ctl(8'hA4, 8'h64);
    `CHK("mass ok", 1'b0, mass_erase_ok_o)
    $display("Test polarity done");
  endtask

  // Polarity zero with open windows, then an unmapped address.
  task automatic t_unprot();
    do_reset(8'hE4);
    wr_ctl(8'h11, 8'h51);
    cmd(1'b0, 16'hE000, 1'b0);
    cmd(1'b0, 16'hDFFF, 1'b1);
    cmd(1'b0, 16'h43FF, 1'b0);
    cmd(1'b0, 16'h4400, 1'b1);
    wr_ctl(8'h31, 8'h71);
    wr_ctl(8'h11, 8'h71);
    apb(1'b1, 8'h08, 32'h00000000);
    `CHK("unmapped err", 1'b1, er)
    apb(1'b0, 8'h08, 32'h00000000);
    `CHK("unmapped data", 32'h00000000, rd)
    wr_ctl(8'h71, 8'h71);
    $display("Test unprot done");
  endtask

  // Every target from scenarios 7 and 6, against the transition table.
  task automatic t_table();
    logic [2:0] t;
    logic [7:0] v;
    logic       ok;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 8; i++) begin
        t = i[2:0];
        v = {t[2], 1'b0, t[1], 2'b00, t[0], 2'b00};
        ok = (f == 0) || (t == 3'd1) || (t == 3'd3) || (t == 3'd4) || (t == 3'd6);
        do_reset((f == 0) ? 8'hE4 : 8'hE0);
        wr_ctl(v, ok ? (v | 8'h40) : 8'hE0);
      end
    end
    $display("Test table done");
  endtask

  // Main sequence.
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    nvm_prot_byte_i = 8'hE4;
    cmd_valid_i = 1'b0;
    cmd_mass_erase_i = 1'b0;
    cmd_addr_i = 16'h0000;
    t_reset_sizes();
    t_high();
    t_polarity();
    t_unprot();
    t_table();
    finish_test();
  end

  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    finish_test();
  end
endmodule
